/* File: atw_host.sv */
// Host-side pin model: convert-start, serial clock, serial input, pulled-up data line
`timescale 1ns/1ns
module atw_host #(
    parameter int QUIET2 = 4
) (
    input  wire logic mclk_i,
    input  wire logic serial_out_i,
    input  wire logic serial_out_oe_i,
    output logic      convert_start_o,
    output logic      serial_clk_o,
    output logic      serial_in_o,
    output logic      line_o
);
    // ****************************************
    // Shared data line with pull-up, one device selected at a time
    // ****************************************
    assign line_o = serial_out_oe_i ? serial_out_i : 1'b1;

    initial begin
        convert_start_o = 1'b0;
        serial_clk_o    = 1'b0;
        serial_in_o     = 1'b1;
    end

    // ****************************************
    // Pin tasks
    // ****************************************
    // Mode 0 turbo, 1 without busy, 2 with busy
    task automatic start_conv(input logic [1:0] mode);
        repeat (QUIET2) @(posedge mclk_i);
        convert_start_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
        // Early drop to reach other devices; mode 1 restores the level long before the end
        if (mode != 2'h0) convert_start_o <= 1'b0;
        repeat (4) @(posedge mclk_i);
        if (mode == 2'h1) convert_start_o <= 1'b1;
    endtask

    task automatic set_start(input logic v);
        @(posedge mclk_i);
        convert_start_o <= v;
    endtask

    // Clock stands still between frames; data taken at each rising edge after the lead edges
    task automatic read_bits(input int lead, input int len, output logic [23:0] bits);
        bits = 24'h0;
        for (int i = -lead; i < len; i++) begin
            #63;
            if (i >= 0) bits[23-i] = line_o;
            serial_clk_o <= 1'b1;
            #62;
            serial_clk_o <= 1'b0;
        end
    endtask
endmodule

/* File: atw_pkg.sv */
// Shared constants and types for the three-wire converter readout
package atw_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] CFG_OFF    = 8'h00;
    localparam logic [7:0] STAT_OFF   = 8'h04;
    localparam logic [7:0] RESULT_OFF = 8'h08;

    // Field positions in the status register
    localparam int STAT_CONV_BUSY_BIT = 0;
    localparam int STAT_READY_BIT     = 1;
    localparam int STAT_FRAME_BIT     = 2;
    localparam int STAT_BUSYMODE_BIT  = 3;

    // ****************************************
    // Configuration layout and reset value
    // ****************************************
    typedef struct packed {
        logic highz;
        logic span;
        logic turbo;
        logic status_en;
    } atw_cfg_t;

    localparam logic [3:0] CFG_RST = 4'h0;

    // ****************************************
    // Frame geometry
    // ****************************************
    localparam int         RESULT_BITS  = 18;
    localparam int         STATUS_BITS  = 6;
    localparam logic [4:0] FRAME_MSB    = 5'h17;
    localparam logic [4:0] LEN_PLAIN    = 5'h12;
    localparam logic [4:0] LEN_STATUS   = 5'h18;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         CONV_TIME_NS  = 300;
    localparam logic [5:0] CONV_CYCLES   = 6'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // Output frame states
    // ****************************************
    typedef enum logic [0:0] {
        FR_HIZ,
        FR_SHIFT
    } atw_frame_t;

endpackage

/* File: atw_readout.sv */
// Three-wire chip-select conversion control and result readout with APB config
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns

// Behaviour
// RL1 - Turbo: rising start with input high converts, floats
// RL2 - Host waits first quiet time before reading
// RL3 - After conversion time, acquire and power down
// RL4 - Start falling edge drives result MSB out
// RL5 - Later bits follow on serial clock falls
// RL6 - Data valid on both serial clock edges
// RL7 - No status: release after eighteenth fall
// RL8 - Turbo status bits on falls nineteen to 24; the code drives them on falls 18 to 23
// RL9 - Release on last fall or start rising
// RL10 - Host leaves second quiet time before start
// RL11 - Turbo cleared for non-turbo modes; reset off
// RL12 - No-busy mode: conversion ignores start pin
// RL13 - No-busy host returns start high in time
// RL14 - Host keeps serial clock still while converting
// RL15 - Host holds serial input high during conversion
// RL16 - Busy mode: output floats until conversion ends
// RL17 - Busy-mode host returns start low in time
// RL18 - Busy mode drives output low at completion
// RL19 - Busy mode: result MSB first, eighteen falls
// RL20 - Busy mode status bits on falls 19-24
// RL21 - Busy mode releases after extra fall/start rise
// RL22 - Shared outputs tolerate brief contention
// RL23 - Turbo frame carries the previous result
// RL24 - Writing turbo bit one enables turbo mode
// RL25 - Status: clamp, span, high-Z, turbo, two zeros
// RL26 - Status bits appended only when enabled
// RL27 - Result MSB first, status directly after
module atw_readout (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        convert_start_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_in_i,
    input  wire logic [17:0] result_i,
    input  wire logic        ov_clamp_i,
    output logic             serial_out_o,
    output logic             serial_out_oe_o,
    output logic             converter_on_o
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [4:0] frame_limit(input logic status_en, input logic busy);
        logic [4:0] len;
        len = status_en ? atw_pkg::LEN_STATUS : atw_pkg::LEN_PLAIN;
        frame_limit = busy ? len + 5'h01 : len;
    endfunction

    function automatic logic pick_bit(input logic [23:0] w, input logic [4:0] idx);
        logic [4:0] pos;
        pos = atw_pkg::FRAME_MSB - idx;
        pick_bit = w[pos];
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    atw_sync #(.WIDTH(3)) u_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .async_i ({convert_start_i, serial_clk_i, serial_in_i}),
        .level_o (pin_lvl),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    wire cnv_lvl  = pin_lvl[2];
    wire cnv_rise = pin_rise[2];
    wire cnv_fall = pin_fall[2];
    wire sck_fall = pin_fall[1];
    wire sdi_lvl  = pin_lvl[0];

    // ****************************************
    // State
    // ****************************************
    atw_pkg::atw_cfg_t   cfg;
    atw_pkg::atw_frame_t frame;
    logic                conv_busy;
    logic [5:0]          conv_cnt;
    logic [17:0]         conv_result;
    logic                data_ready;
    logic [23:0]         out_word;
    logic [4:0]          bit_cnt;
    logic                busy_mode;

    // ****************************************
    // APB slave
    // ****************************************
    wire        hit_cfg  = paddr_i == atw_pkg::CFG_OFF;
    wire        hit_stat = paddr_i == atw_pkg::STAT_OFF;
    wire        hit_res  = paddr_i == atw_pkg::RESULT_OFF;
    wire        hit_any  = hit_cfg | hit_stat | hit_res;
    wire        next_pready = psel_i & penable_i & ~pready_o;
    wire        apb_done = psel_i & penable_i & pready_o;
    wire        wr_cfg   = apb_done & pwrite_i & hit_cfg;
    wire [31:0] stat_word;
    wire [31:0] rd_mux;

    assign stat_word = {28'h0000000, busy_mode, frame == atw_pkg::FR_SHIFT, data_ready, conv_busy};
    assign rd_mux    = hit_cfg  ? {28'h0000000, cfg} :
                       hit_stat ? stat_word :
                       hit_res  ? {14'h0000, conv_result} : 32'h00000000;

    // One wait state: pready rises in the first access cycle's following edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= next_pready;
            pslverr_o <= next_pready & ~hit_any;
            if (next_pready) begin
                prdata_o <= (pwrite_i | ~hit_any) ? 32'h00000000 : rd_mux;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cfg <= atw_pkg::CFG_RST; // see RL11
        end else if (wr_cfg) begin
            cfg <= pwdata_i[3:0]; // see RL24
        end
    end

    // ****************************************
    // Conversion timer
    // ****************************************
    // Starts need the serial input high; a start while busy is ignored
    wire start_go  = cnv_rise & sdi_lvl & ~conv_busy; // see RL1
    wire conv_done = conv_busy & (conv_cnt == atw_pkg::CONV_CYCLES - 6'h01);
    // Start pin level at completion picks busy or no-busy readout
    wire busy_go   = conv_done & ~cfg.turbo & ~cnv_lvl;
    wire [5:0] status_bits = {ov_clamp_i, cfg.span, cfg.highz, cfg.turbo, 2'b00}; // see RL25

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            conv_busy   <= 1'b0;
            conv_cnt    <= 6'h00;
            conv_result <= 18'h00000;
        end else if (start_go) begin
            conv_busy <= 1'b1;
            conv_cnt  <= 6'h00;
        end else if (conv_done) begin
            conv_busy   <= 1'b0; // see RL3
            conv_result <= result_i;
        end else if (conv_busy) begin
            conv_cnt <= conv_cnt + 6'h01; // see RL12
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            converter_on_o <= 1'b0;
        end else begin
            converter_on_o <= start_go | (conv_busy & ~conv_done); // see RL3
        end
    end

    // A start fall opens a frame only when a word waits and no non-turbo conversion runs
    wire read_go = cnv_fall & (frame == atw_pkg::FR_HIZ) & data_ready & (cfg.turbo | ~conv_busy);

    // ****************************************
    // Readout word
    // ****************************************
    // Turbo reads the previous result, so the word is frozen at the start
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            out_word   <= 24'h000000;
            data_ready <= 1'b0;
        end else if (start_go & cfg.turbo) begin
            out_word   <= {conv_result, status_bits}; // see RL23
            data_ready <= 1'b1;
        end else if (start_go) begin
            data_ready <= 1'b0;
        end else if (conv_done & ~cfg.turbo) begin
            out_word   <= {result_i, status_bits}; // see RL27
            data_ready <= ~busy_go;
        end else if (read_go) begin
            data_ready <= 1'b0;
        end
    end

    // ****************************************
    // Serial output frame
    // ****************************************
    wire [4:0] next_cnt = bit_cnt + 5'h01;
    wire [4:0] limit    = frame_limit(cfg.status_en, busy_mode); // see RL26
    wire [4:0] next_idx = busy_mode ? bit_cnt : next_cnt;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            frame           <= atw_pkg::FR_HIZ;
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
            bit_cnt         <= 5'h00;
            busy_mode       <= 1'b0;
        end else if (cnv_rise) begin
            frame           <= atw_pkg::FR_HIZ; // see RL1, RL9, RL21
            serial_out_oe_o <= 1'b0;
        end else if (busy_go) begin
            frame           <= atw_pkg::FR_SHIFT;
            busy_mode       <= 1'b1;
            serial_out_oe_o <= 1'b1;
            serial_out_o    <= 1'b0; // see RL18
            bit_cnt         <= 5'h00;
        end else if (read_go) begin
            frame           <= atw_pkg::FR_SHIFT;
            busy_mode       <= 1'b0;
            serial_out_oe_o <= 1'b1;
            serial_out_o    <= out_word[atw_pkg::FRAME_MSB]; // see RL4
            bit_cnt         <= 5'h00;
        end else if ((frame == atw_pkg::FR_SHIFT) & sck_fall) begin
            bit_cnt <= next_cnt;
            if (next_cnt == limit) begin
                frame           <= atw_pkg::FR_HIZ; // see RL7, RL9, RL21
                serial_out_oe_o <= 1'b0;
            end else begin
                // Bit stands a full serial clock period, valid at both edges
                serial_out_o <= pick_bit(out_word, next_idx); // see RL5, RL6, RL8, RL19, RL20
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_TURBO_OFF_AFTER_RESET: assert property (@(posedge mclk_i) // see RL11
        srst_i |=> !cfg.turbo)
        else $error("turbo not cleared by reset");

    AST_START_FLOATS_OUTPUT: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL1
        start_go |=> !serial_out_oe_o ##1 !serial_out_oe_o)
        else $error("output driven right after conversion start");

    AST_CONV_LENGTH: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL3
        $fell(conv_busy) |-> $past(conv_cnt) == atw_pkg::CONV_CYCLES - 6'h01 ##1 !converter_on_o)
        else $error("conversion length wrong or converter left on");

    AST_MSB_ON_START_FALL: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL4
        read_go && !cnv_rise |=> serial_out_oe_o && serial_out_o == $past(out_word[23]))
        else $error("MSB not driven on start falling edge");

    AST_NEXT_BIT: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL5
        (frame == atw_pkg::FR_SHIFT) && sck_fall && !cnv_rise && next_cnt != limit
        |=> serial_out_o == pick_bit(out_word, $past(next_idx)))
        else $error("wrong bit after serial clock fall");

    AST_RELEASE_AT_LIMIT: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL7
        (frame == atw_pkg::FR_SHIFT) && sck_fall && !cnv_rise
        && bit_cnt == frame_limit(cfg.status_en, busy_mode) - 5'h01 |=> !serial_out_oe_o)
        else $error("output not released at last fall");

    AST_RELEASE_ON_RISE: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL9
        cnv_rise |=> !serial_out_oe_o)
        else $error("output not released on start rising");

    AST_BUSY_FLOATS: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL16
        conv_busy && !cfg.turbo && $past(conv_busy) |-> !serial_out_oe_o)
        else $error("output driven during non-turbo conversion");

    AST_BUSY_LOW: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL18
        busy_go |=> serial_out_oe_o && !serial_out_o && busy_mode)
        else $error("busy indication missing at completion");

    AST_TURBO_PREVIOUS: assert property (@(posedge mclk_i) disable iff (srst_i) // see RL23
        start_go && cfg.turbo |=> out_word[23:6] == $past(conv_result))
        else $error("turbo frame not loaded with previous result");

endmodule

/* File: atw_readout_tb.sv */
// Self-checking bench for the three-wire readout block
`timescale 1ns/1ns
module atw_readout_tb;
    logic        mclk_i;
    logic        srst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        convert_start_i;
    logic        serial_clk_i;
    logic        serial_in_i;
    logic [17:0] result_i;
    logic        ov_clamp_i;
    logic        serial_out_o;
    logic        serial_out_oe_o;
    logic        converter_on_o;
    logic        line;
    logic [31:0] rd;
    logic        err;
    logic [23:0] bits;
    logic [23:0] exp;
    logic [17:0] prev;
    logic [4:0]  len;
    logic [3:0]  cfg;
    logic [1:0]  mode;
    logic        ov;
    logic [17:0] res;
    int          errors;
    int          check_count;
    int          cycles;
    int          on_cnt;

    // ****************************************
    // Rows: length, config, mode, clamp flag, code
    // ****************************************
    logic [29:0] rows [7] = '{
        {5'h12, 4'h0, 2'h1, 1'h0, 18'h2AAAA},
        {5'h18, 4'h1, 2'h1, 1'h1, 18'h3FFFF},
        {5'h12, 4'h0, 2'h2, 1'h0, 18'h00001},
        {5'h18, 4'hD, 2'h2, 1'h0, 18'h15555},
        {5'h12, 4'h2, 2'h0, 1'h1, 18'h3C3C3},
        {5'h18, 4'h3, 2'h0, 1'h1, 18'h0F0F0},
        {5'h12, 4'h0, 2'h1, 1'h0, 18'h00000}
    };

    atw_readout atw_readout_inst (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .convert_start_i(convert_start_i), .serial_clk_i(serial_clk_i), .serial_in_i(serial_in_i),
        .result_i(result_i), .ov_clamp_i(ov_clamp_i), .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o), .converter_on_o(converter_on_o));

    atw_host atw_host_inst (.mclk_i(mclk_i), .serial_out_i(serial_out_o),
        .serial_out_oe_i(serial_out_oe_o), .convert_start_o(convert_start_i),
        .serial_clk_o(serial_clk_i), .serial_in_o(serial_in_i), .line_o(line));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic give_verdict;
        $display("Counts: %0d checks, %0d errors", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end

    // Length of every power-up of the conversion circuitry
    always @(posedge mclk_i) begin
        if (converter_on_o === 1'b1) begin
            on_cnt++;
        end else if (on_cnt != 0) begin
            check(32'(on_cnt), 32'(atw_pkg::CONV_CYCLES));
            on_cnt = 0;
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) @(posedge mclk_i);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    initial begin
        srst_i     = 1'b1;
        psel_i     = 1'b0;
        penable_i  = 1'b0;
        pwrite_i   = 1'b0;
        paddr_i    = 8'h00;
        pwdata_i   = 32'h0;
        result_i   = 18'h0;
        ov_clamp_i = 1'b0;
        prev       = 18'h0;
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        apb(1'b0, atw_pkg::CFG_OFF, 32'h0);
        check(rd, 32'h0);
        foreach (rows[n]) begin
            {len, cfg, mode, ov, res} = rows[n];
            apb(1'b1, atw_pkg::CFG_OFF, {28'h0, cfg});
            result_i   <= res;
            ov_clamp_i <= ov;
            atw_host_inst.start_conv(mode);
            check({31'h0, serial_out_oe_o}, 32'h0);
            // Serial clock kept still until the conversion is over in modes 1 and 2
            if (mode != 2'h0) repeat (40) @(posedge mclk_i);
            if (mode == 2'h2) check({31'h0, line}, 32'h0);
            if (mode != 2'h2) atw_host_inst.set_start(1'b0);
            atw_host_inst.read_bits(int'(mode == 2'h2), int'(len), bits);
            exp = {(cfg[1] ? prev : res), ov, cfg[2], cfg[3], cfg[1], 2'h0};
            if (len == 5'h12) exp[5:0] = 6'h0;
            check({8'h0, bits}, {8'h0, exp});
            repeat (5) @(posedge mclk_i);
            // Busy frame: the lead fall plus len falls already include the extra fall
            if (mode == 2'h2) begin
                check({31'h0, serial_out_oe_o}, 32'h0);
                atw_host_inst.read_bits(1, 0, bits);
                repeat (5) @(posedge mclk_i);
            end
            check({31'h0, serial_out_oe_o}, 32'h0);
            apb(1'b0, atw_pkg::RESULT_OFF, 32'h0);
            check(rd, {14'h0, res});
            prev = res;
        end
        // Frame cut short by a new convert-start rise
        atw_host_inst.start_conv(2'h1);
        repeat (40) @(posedge mclk_i);
        atw_host_inst.set_start(1'b0);
        atw_host_inst.read_bits(0, 5, bits);
        check({27'h0, bits[23:19]}, 32'h0);
        atw_host_inst.set_start(1'b1);
        repeat (6) @(posedge mclk_i);
        check({31'h0, serial_out_oe_o}, 32'h0);
        repeat (40) @(posedge mclk_i);
        atw_host_inst.set_start(1'b0);
        // Register edges, then a reset in mid-run
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, atw_pkg::CFG_OFF, 32'hFFFFFFFF);
        apb(1'b0, atw_pkg::CFG_OFF, 32'h0);
        check(rd, 32'h0000000F);
        @(posedge mclk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        apb(1'b0, atw_pkg::CFG_OFF, 32'h0);
        check(rd, 32'h0);
        check({31'h0, serial_out_oe_o}, 32'h0);
        // Start rise with serial input low must not convert
        @(posedge mclk_i);
        atw_host_inst.serial_in_o <= 1'b0;
        atw_host_inst.start_conv(2'h1);
        check({31'h0, converter_on_o}, 32'h0);
        give_verdict();
    end
endmodule

/* File: atw_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
module atw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] last;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta  <= '0;
            stage <= '0;
            last  <= '0;
        end else begin
            meta  <= async_i;
            stage <= meta;
            last  <= stage;
        end
    end

    // Edges look only at the second stage and its delayed copy
    assign level_o = stage;
    assign rise_o  = stage & ~last;
    assign fall_o  = ~stage & last;
endmodule
